// File: ims_consts.svh
// Register offsets, field positions, reset values and widths of the status and mask block
`ifndef IMS_CONSTS_SVH
`define IMS_CONSTS_SVH

// Byte offsets on the register bus
`define IMS_TXTHR_OFF 8'h1c
`define IMS_RXTHR_OFF 8'h20
`define IMS_BAUD_OFF 8'h28
`define IMS_MASK_OFF 8'h2c
`define IMS_RAW_OFF 8'h30
`define IMS_CLR_OFF 8'h34

// Widths
`define IMS_BAUD_W 16
`define IMS_THR_W 10
`define IMS_LVL_W 11
`define IMS_FLAG_W 7

// Reset values
`define IMS_BAUD_RST 16'h0008
`define IMS_MASK_RST 32'h0000_0000
`define IMS_THR_RST 10'h000
`define IMS_FLAG_RST 7'h13

// Implemented mask bits and bits supplied by the protocol engine
`define IMS_MASK_USED 32'h131f_007f
`define IMS_EXT_USED 32'h131f_0000

// Low raw status field positions
`define IMS_TX_EMPTY 0
`define IMS_TX_LOW 1
`define IMS_TX_FULL 2
`define IMS_TX_OVR 3
`define IMS_RX_EMPTY 4
`define IMS_RX_HIGH 5
`define IMS_RX_FULL 6

// Protocol engine event positions in the mask and raw status words
`define IMS_SLV_RD_REQ 16
`define IMS_SLV_RD_STARVE 17
`define IMS_SLV_WR_REQ 18
`define IMS_MST_DONE 19
`define IMS_SLV_DONE 20
`define IMS_ARB_LOST 24
`define IMS_BUS_FAULT 25
`define IMS_MST_NOSTOP 28

`endif

// File: ims_fifo_model.sv
// Queue model standing in for the transmit and receive FIFOs
`timescale 1ns/1ps
module ims_fifo_model #(
  parameter int DEPTH = 4,
  parameter int RDEPTH = 7
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bench requests
  input wire logic push_i,
  input wire logic pop_i,
  input wire logic [10:0] rx_set_i,
  // FIFO conditions
  output logic [10:0] tx_level_o,
  output logic tx_full_o,
  output logic tx_write_o,
  output logic [10:0] rx_level_o,
  output logic rx_full_o
);
  // Strobe is combinational so the block sees it with the pre-write full state
  assign tx_write_o = push_i;
  assign tx_full_o = tx_level_o == 11'(DEPTH);
  assign rx_full_o = rx_level_o == 11'(RDEPTH);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_level_o <= 11'h000;
      rx_level_o <= 11'h000;
    end else begin
      rx_level_o <= rx_set_i;
      // A write into a full queue is lost
      if (push_i && !tx_full_o) tx_level_o <= tx_level_o + 11'h001;
      else if (!push_i && pop_i && tx_level_o != 11'h000) tx_level_o <= tx_level_o - 11'h001;
    end
  end
endmodule : ims_fifo_model

// File: ims_pkg.sv
// Types of the status and mask block
`include "ims_consts.svh"

package ims_pkg;

  typedef struct packed {
    logic [`IMS_BAUD_W-1:0] baud;
    logic [31:0] mask;
    logic [`IMS_THR_W-1:0] tx_thr;
    logic [`IMS_THR_W-1:0] rx_thr;
    logic [`IMS_FLAG_W-1:0] flags;
    logic irq;
    logic ack;
    logic [31:0] rdata;
  } ims_state_t;

endpackage : ims_pkg

// File: ims_status.sv
// Baud count, interrupt mask and low raw status registers behind a Wishbone slave
`timescale 1ns/1ps
`include "ims_consts.svh"

module ims_status (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // FIFO conditions
  input wire logic [`IMS_LVL_W-1:0] tx_level_i,
  input wire logic tx_full_i,
  input wire logic tx_write_i,
  input wire logic [`IMS_LVL_W-1:0] rx_level_i,
  input wire logic rx_full_i,
  // Protocol engine events, raw status bit positions 16 and up
  input wire logic [31:0] ext_raw_i,
  // Outputs to the protocol engine and interrupt controller
  output logic [`IMS_BAUD_W-1:0] baud_count_o,
  output logic irq_o
);

  localparam ims_pkg::ims_state_t ST_RST = '{
    baud: `IMS_BAUD_RST,
    mask: `IMS_MASK_RST,
    tx_thr: `IMS_THR_RST,
    rx_thr: `IMS_THR_RST,
    flags: `IMS_FLAG_RST,
    irq: 1'b0,
    ack: 1'b0,
    rdata: 32'h0000_0000
  };

  ims_pkg::ims_state_t st_ff;
  ims_pkg::ims_state_t nxt_st;

  logic acc;
  logic wr;
  logic clr_ovr;
  logic [31:0] raw_cur;
  logic [31:0] raw_nxt;

  // Word address match, byte offsets are word aligned
  function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
    hit = (adr[7:2] == off[7:2]);
  endfunction : hit

  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val, input logic [3:0] sel);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        merge[i*8 +: 8] = val[i*8 +: 8];
      end
    end
  endfunction : merge

  // Assemble the full raw status word
  function automatic logic [31:0] raw_word(input logic [`IMS_FLAG_W-1:0] flags, input logic [31:0] ext);
    raw_word = (ext & `IMS_EXT_USED) | {25'h0000000, flags};
  endfunction : raw_word

  // Commit happens at the edge where the master samples ack high
  assign acc = cyc_i && stb_i && st_ff.ack;
  assign wr = acc && we_i;
  assign clr_ovr = wr && hit(adr_i, `IMS_CLR_OFF) && sel_i[0] && dat_i[`IMS_TX_OVR];
  assign raw_cur = raw_word(st_ff.flags, ext_raw_i);

  always_comb begin
    nxt_st = st_ff;
    raw_nxt = 32'h0000_0000;
    // Ack one cycle after the request, dropped right after
    nxt_st.ack = cyc_i && stb_i && !st_ff.ack;
    if (cyc_i && stb_i && !st_ff.ack && !we_i) begin
      if (hit(adr_i, `IMS_BAUD_OFF)) begin
        nxt_st.rdata = {16'h0000, st_ff.baud};
      end else if (hit(adr_i, `IMS_MASK_OFF)) begin
        nxt_st.rdata = st_ff.mask;
      end else if (hit(adr_i, `IMS_RAW_OFF)) begin
        nxt_st.rdata = raw_cur;
      end else if (hit(adr_i, `IMS_TXTHR_OFF)) begin
        nxt_st.rdata = {22'h000000, st_ff.tx_thr};
      end else if (hit(adr_i, `IMS_RXTHR_OFF)) begin
        nxt_st.rdata = {22'h000000, st_ff.rx_thr};
      end else begin
        // Unmapped and write-only offsets read as zero
        nxt_st.rdata = 32'h0000_0000;
      end
    end
    if (wr) begin
      if (hit(adr_i, `IMS_BAUD_OFF)) begin
        nxt_st.baud = `IMS_BAUD_W'(merge({16'h0000, st_ff.baud}, dat_i, sel_i));
      end
      // Mask write, reserved bits stay zero
      if (hit(adr_i, `IMS_MASK_OFF)) begin
        nxt_st.mask = merge(st_ff.mask, dat_i, sel_i) & `IMS_MASK_USED;
      end
      if (hit(adr_i, `IMS_TXTHR_OFF)) begin
        nxt_st.tx_thr = `IMS_THR_W'(merge({22'h000000, st_ff.tx_thr}, dat_i, sel_i));
      end
      if (hit(adr_i, `IMS_RXTHR_OFF)) begin
        nxt_st.rx_thr = `IMS_THR_W'(merge({22'h000000, st_ff.rx_thr}, dat_i, sel_i));
      end
    end
    nxt_st.flags[`IMS_TX_EMPTY] = (tx_level_i == '0);
    nxt_st.flags[`IMS_TX_LOW] = (tx_level_i <= {1'b0, st_ff.tx_thr});
    nxt_st.flags[`IMS_TX_FULL] = tx_full_i;
    // Sticky overrun, a new overrun wins over a clear
    if (tx_write_i && tx_full_i) begin
      nxt_st.flags[`IMS_TX_OVR] = 1'b1;
    end else if (clr_ovr) begin
      nxt_st.flags[`IMS_TX_OVR] = 1'b0;
    end
    nxt_st.flags[`IMS_RX_EMPTY] = (rx_level_i == '0);
    nxt_st.flags[`IMS_RX_HIGH] = (rx_level_i >= {1'b0, st_ff.rx_thr});
    nxt_st.flags[`IMS_RX_FULL] = rx_full_i;
    // Masked raw events drive the request
    raw_nxt = raw_word(nxt_st.flags, ext_raw_i);
    nxt_st.irq = |(raw_nxt & nxt_st.mask);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= ST_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign dat_o = st_ff.rdata;
  assign ack_o = st_ff.ack;
  assign baud_count_o = st_ff.baud;
  assign irq_o = st_ff.irq;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_req;
    cyc_i && stb_i && !ack_o;
  endsequence

  sequence s_commit(logic [7:0] off);
    cyc_i && stb_i && we_i && ack_o && hit(adr_i, off) && (sel_i == 4'hf);
  endsequence

  sequence s_write(logic [7:0] off);
    cyc_i && stb_i && we_i && ack_o && hit(adr_i, off);
  endsequence

  sequence s_read(logic [7:0] off);
    cyc_i && stb_i && !we_i && !ack_o && hit(adr_i, off);
  endsequence

  a_baud_reset_value: assert property ($past(rst_i) |-> baud_count_o == `IMS_BAUD_RST)
    else $error("baud count not at reset value after reset");

  a_baud_write_lands: assert property (s_commit(`IMS_BAUD_OFF) |=> baud_count_o == $past(dat_i[15:0]))
    else $error("baud count write lost");

  a_mask_write_lands: assert property (s_commit(`IMS_MASK_OFF) |=> st_ff.mask == ($past(dat_i) & `IMS_MASK_USED))
    else $error("mask write lost");

  a_mask_reset_zero: assert property ($past(rst_i) |-> st_ff.mask == `IMS_MASK_RST && !irq_o)
    else $error("mask not clear after reset");

  // Event levels reach the request one cycle late, so compare against the previous sample
  a_irq_gating: assert property (irq_o == |(raw_word(st_ff.flags, $past(ext_raw_i)) & st_ff.mask))
    else $error("interrupt does not match masked status");

  a_tx_empty_flag: assert property (1'b1 |=> st_ff.flags[`IMS_TX_EMPTY] == ($past(tx_level_i) == '0))
    else $error("tx empty flag wrong");

  a_tx_low_flag: assert property (1'b1 |=> st_ff.flags[`IMS_TX_LOW] == ($past(tx_level_i) <= {1'b0, $past(st_ff.tx_thr)}))
    else $error("tx low flag wrong");

  a_tx_full_flag: assert property (1'b1 |=> st_ff.flags[`IMS_TX_FULL] == $past(tx_full_i))
    else $error("tx full flag missed");

  a_ovr_set: assert property (tx_write_i && tx_full_i |=> st_ff.flags[`IMS_TX_OVR] [*1])
    else $error("overrun not latched");

  a_ovr_sticky: assert property (st_ff.flags[`IMS_TX_OVR] && !clr_ovr |=> st_ff.flags[`IMS_TX_OVR])
    else $error("overrun cleared without clear write");

  a_ovr_clear: assert property (clr_ovr && !(tx_write_i && tx_full_i) |=> !st_ff.flags[`IMS_TX_OVR])
    else $error("overrun clear ignored");

  a_rx_empty_flag: assert property (1'b1 |=> st_ff.flags[`IMS_RX_EMPTY] == ($past(rx_level_i) == '0))
    else $error("rx empty flag wrong");

  a_rx_high_flag: assert property (1'b1 |=> st_ff.flags[`IMS_RX_HIGH] == ($past(rx_level_i) >= {1'b0, $past(st_ff.rx_thr)}))
    else $error("rx high flag wrong");

  a_rx_full_flag: assert property (1'b1 |=> st_ff.flags[`IMS_RX_FULL] == $past(rx_full_i))
    else $error("rx full flag wrong");

  a_bus_ack_timing: assert property (s_req |=> ack_o ##1 !ack_o)
    else $error("ack not a single cycle after request");

  a_gate_tx_empty: assert property (st_ff.flags[`IMS_TX_EMPTY] && st_ff.mask[`IMS_TX_EMPTY] |-> irq_o)
    else $error("tx empty event not passed");

  a_gate_tx_low: assert property (st_ff.flags[`IMS_TX_LOW] && st_ff.mask[`IMS_TX_LOW] |-> irq_o)
    else $error("tx low event not passed");

  a_gate_tx_full: assert property (st_ff.flags[`IMS_TX_FULL] && st_ff.mask[`IMS_TX_FULL] |-> irq_o)
    else $error("tx full event not passed");

  a_gate_tx_overrun: assert property (st_ff.flags[`IMS_TX_OVR] && st_ff.mask[`IMS_TX_OVR] |-> irq_o)
    else $error("overrun event not passed");

  a_gate_rx_empty: assert property (st_ff.flags[`IMS_RX_EMPTY] && st_ff.mask[`IMS_RX_EMPTY] |-> irq_o)
    else $error("rx empty event not passed");

  a_gate_rx_high: assert property (st_ff.flags[`IMS_RX_HIGH] && st_ff.mask[`IMS_RX_HIGH] |-> irq_o)
    else $error("rx high event not passed");

  a_gate_rx_full: assert property (st_ff.flags[`IMS_RX_FULL] && st_ff.mask[`IMS_RX_FULL] |-> irq_o)
    else $error("rx full event not passed");

  a_gate_rd_request: assert property ($past(ext_raw_i[`IMS_SLV_RD_REQ]) && st_ff.mask[`IMS_SLV_RD_REQ] |-> irq_o)
    else $error("slave read request not passed");

  a_gate_rd_starved: assert property ($past(ext_raw_i[`IMS_SLV_RD_STARVE]) && st_ff.mask[`IMS_SLV_RD_STARVE] |-> irq_o)
    else $error("slave read starved not passed");

  a_gate_wr_request: assert property ($past(ext_raw_i[`IMS_SLV_WR_REQ]) && st_ff.mask[`IMS_SLV_WR_REQ] |-> irq_o)
    else $error("slave write request not passed");

  a_gate_master_done: assert property ($past(ext_raw_i[`IMS_MST_DONE]) && st_ff.mask[`IMS_MST_DONE] |-> irq_o)
    else $error("master done not passed");

  a_gate_slave_done: assert property ($past(ext_raw_i[`IMS_SLV_DONE]) && st_ff.mask[`IMS_SLV_DONE] |-> irq_o)
    else $error("slave done not passed");

  a_gate_arb_lost: assert property ($past(ext_raw_i[`IMS_ARB_LOST]) && st_ff.mask[`IMS_ARB_LOST] |-> irq_o)
    else $error("arbitration lost not passed");

  a_gate_bus_fault: assert property ($past(ext_raw_i[`IMS_BUS_FAULT]) && st_ff.mask[`IMS_BUS_FAULT] |-> irq_o)
    else $error("bus fault not passed");

  a_gate_master_nostop: assert property ($past(ext_raw_i[`IMS_MST_NOSTOP]) && st_ff.mask[`IMS_MST_NOSTOP] |-> irq_o)
    else $error("master done without stop not passed");

  a_gate_blocks: assert property (!(|(raw_word(st_ff.flags, $past(ext_raw_i)) & st_ff.mask)) |-> !irq_o)
    else $error("masked event reached the interrupt");

  a_mask_reserved_zero: assert property ((st_ff.mask & ~`IMS_MASK_USED) == 32'h0000_0000)
    else $error("reserved mask bit stored");

  a_flags_reset_value: assert property ($past(rst_i) |-> st_ff.flags == `IMS_FLAG_RST)
    else $error("status flags not at reset value");

  a_thr_reset_zero: assert property ($past(rst_i) |-> st_ff.tx_thr == `IMS_THR_RST && st_ff.rx_thr == `IMS_THR_RST)
    else $error("thresholds not clear after reset");

  a_ack_reset_low: assert property ($past(rst_i) |-> !ack_o)
    else $error("ack high right after reset");

  a_txthr_write_lands: assert property (s_commit(`IMS_TXTHR_OFF) |=> st_ff.tx_thr == $past(dat_i[`IMS_THR_W-1:0]))
    else $error("tx threshold write lost");

  a_rxthr_write_lands: assert property (s_commit(`IMS_RXTHR_OFF) |=> st_ff.rx_thr == $past(dat_i[`IMS_THR_W-1:0]))
    else $error("rx threshold write lost");

  a_baud_lane_merge: assert property (s_write(`IMS_BAUD_OFF) ##0 (sel_i == 4'h1) |=>
    baud_count_o == {$past(baud_count_o[15:8]), $past(dat_i[7:0])})
    else $error("baud byte lane merge wrong");

  a_baud_holds: assert property (!(wr && hit(adr_i, `IMS_BAUD_OFF)) |=> $stable(baud_count_o))
    else $error("baud count changed without write");

  a_mask_holds: assert property (!(wr && hit(adr_i, `IMS_MASK_OFF)) |=> $stable(st_ff.mask))
    else $error("mask changed without write");

  a_txthr_holds: assert property (!(wr && hit(adr_i, `IMS_TXTHR_OFF)) |=> $stable(st_ff.tx_thr))
    else $error("tx threshold changed without write");

  a_rxthr_holds: assert property (!(wr && hit(adr_i, `IMS_RXTHR_OFF)) |=> $stable(st_ff.rx_thr))
    else $error("rx threshold changed without write");

  a_read_baud: assert property (s_read(`IMS_BAUD_OFF) |=> dat_o == {16'h0000, $past(baud_count_o)})
    else $error("baud read data wrong");

  a_read_mask: assert property (s_read(`IMS_MASK_OFF) |=> dat_o == $past(st_ff.mask))
    else $error("mask read data wrong");

  a_read_raw_low: assert property (s_read(`IMS_RAW_OFF) |=> dat_o[`IMS_FLAG_W-1:0] == $past(st_ff.flags))
    else $error("low raw status read wrong");

  a_read_raw_ext: assert property (s_read(`IMS_RAW_OFF) |=>
    (dat_o & `IMS_EXT_USED) == ($past(ext_raw_i) & `IMS_EXT_USED))
    else $error("event raw status read wrong");

  a_read_txthr: assert property (s_read(`IMS_TXTHR_OFF) |=> dat_o == {22'h000000, $past(st_ff.tx_thr)})
    else $error("tx threshold read wrong");

  a_read_rxthr: assert property (s_read(`IMS_RXTHR_OFF) |=> dat_o == {22'h000000, $past(st_ff.rx_thr)})
    else $error("rx threshold read wrong");

  a_read_clear_zero: assert property (s_read(`IMS_CLR_OFF) |=> dat_o == 32'h0000_0000)
    else $error("clear register read not zero");

  a_ack_needs_req: assert property (!(cyc_i && stb_i) |=> !ack_o)
    else $error("ack without request");

  a_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");

  a_rdata_hold: assert property (!(cyc_i && stb_i && !we_i && !ack_o) |=> $stable(dat_o))
    else $error("read data changed without read");

  a_ovr_set_wins: assert property (tx_write_i && tx_full_i && clr_ovr |=> st_ff.flags[`IMS_TX_OVR])
    else $error("clear won over a new overrun");

  a_ovr_no_false: assert property (!st_ff.flags[`IMS_TX_OVR] && !(tx_write_i && tx_full_i) |=> !st_ff.flags[`IMS_TX_OVR])
    else $error("overrun set without a lost write");

  a_tx_empty_low: assert property (st_ff.flags[`IMS_TX_EMPTY] |-> st_ff.flags[`IMS_TX_LOW])
    else $error("empty tx queue not below threshold");

endmodule : ims_status

// File: ims_status_bench.sv
// Self-checking bench of the status and mask block
`timescale 1ns/1ps
`include "ims_consts.svh"
module ims_status_bench;
  localparam int DEPTH = 4;
  localparam int RDEPTH = 7;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, push = 1'b0, pop = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hf;
  logic [31:0] dat = 32'h0, ext = 32'h0, rdat, q, msk = 32'h0, r = 32'h59ce;
  logic [10:0] rxs = 11'h0, txl, rxl;
  logic [15:0] baud;
  logic ack, irq, txf, txw, rxf;
  int err_count = 0, checks = 0, tl = 0, rl = 0, tthr = 0, rthr = 0, ovr = 0;
  initial forever #20 clk_i = ~clk_i;
  ims_fifo_model #(.DEPTH(DEPTH), .RDEPTH(RDEPTH)) i_ims_fifo_model (.clk_i(clk_i), .rst_i(rst_i),
    .push_i(push), .pop_i(pop), .rx_set_i(rxs), .tx_level_o(txl), .tx_full_o(txf), .tx_write_o(txw),
    .rx_level_o(rxl), .rx_full_o(rxf));
  ims_status i_ims_status (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(dat), .dat_o(rdat), .ack_o(ack), .tx_level_i(txl), .tx_full_i(txf),
    .tx_write_i(txw), .rx_level_i(rxl), .rx_full_i(rxf), .ext_raw_i(ext), .baud_count_o(baud), .irq_o(irq));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h0040_0007 : 32'h0);
  endfunction : lfsr
  function automatic logic [31:0] exp_raw();
    logic [31:0] e;
    e = ext & `IMS_EXT_USED;
    e[6:0] = {rl == RDEPTH, rl >= rthr, rl == 0, ovr != 0, tl == DEPTH, tl <= tthr, tl == 0};
    return e;
  endfunction : exp_raw
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk
  task automatic chk_irq(input logic e, input logic g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk_irq
  // Classic cycle: hold until ack, then release for a cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] o);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    @(posedge clk_i);
    // Only the watchdog ends a wait that never sees ack
    while (ack !== 1'b1) begin
      @(posedge clk_i);
    end
    o = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  task automatic finish_test();
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : finish_test
  initial begin
    repeat (5000) @(posedge clk_i);
    err_count++;
    finish_test();
  end
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, `IMS_BAUD_OFF, 32'h0, q);
    chk(32'h8, q);
    wb(1'b0, `IMS_MASK_OFF, 32'h0, q);
    chk(32'h0, q);
    wb(1'b0, `IMS_RAW_OFF, 32'h0, q);
    chk(exp_raw(), q);
    wb(1'b0, 8'h3c, 32'h0, q);
    chk(32'h0, q);
    wb(1'b1, `IMS_BAUD_OFF, r, q);
    wb(1'b0, `IMS_BAUD_OFF, 32'h0, q);
    chk(r & 32'hffff, q);
    chk(r & 32'hffff, {16'h0, baud});
    sel <= 4'h1;
    wb(1'b1, `IMS_BAUD_OFF, 32'h0000_00a5, q);
    sel <= 4'hf;
    wb(1'b0, `IMS_BAUD_OFF, 32'h0, q);
    chk({16'h0, r[15:8], 8'ha5}, q);
    wb(1'b1, `IMS_RXTHR_OFF, ~r, q);
    wb(1'b0, `IMS_RXTHR_OFF, 32'h0, q);
    chk(~r & 32'h3ff, q);
    wb(1'b1, `IMS_MASK_OFF, 32'hffff_ffff, q);
    wb(1'b0, `IMS_MASK_OFF, 32'h0, q);
    chk(`IMS_MASK_USED, q);
    repeat (60) begin
      r = lfsr(r);
      wb(1'b1, `IMS_TXTHR_OFF, 32'(r[2:0]), q);
      wb(1'b1, `IMS_RXTHR_OFF, 32'(r[8:6]), q);
      msk = lfsr(r);
      wb(1'b1, `IMS_MASK_OFF, msk, q);
      ext <= lfsr(msk);
      msk = msk & `IMS_MASK_USED;
      if (r[11]) wb(1'b1, `IMS_CLR_OFF, 32'h8, q);
      if (r[11]) ovr = 0;
      tthr = r[2:0];
      rthr = r[8:6];
      rl = r[5:3];
      rxs <= r[5:3];
      push <= r[9];
      pop <= r[10] & ~r[9];
      @(posedge clk_i);
      push <= 1'b0;
      pop <= 1'b0;
      if (r[9] && tl == DEPTH) ovr = 1;
      else if (r[9]) tl++;
      else if (r[10] && tl > 0) tl--;
      repeat (2) @(posedge clk_i);
      wb(1'b0, `IMS_RAW_OFF, 32'h0, q);
      chk(exp_raw(), q);
      chk_irq(|(exp_raw() & msk), irq);
    end
    // Flush the queue before clearing overrun
    pop <= 1'b1;
    repeat (DEPTH) @(posedge clk_i);
    pop <= 1'b0;
    tl = 0;
    wb(1'b1, `IMS_CLR_OFF, 32'h8, q);
    ovr = 0;
    wb(1'b0, `IMS_RAW_OFF, 32'h0, q);
    chk(exp_raw(), q);
    // Reset in mid-run must bring back the documented values
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, `IMS_BAUD_OFF, 32'h0, q);
    chk(32'h8, q);
    wb(1'b0, `IMS_MASK_OFF, 32'h0, q);
    chk(32'h0, q);
    chk_irq(1'b0, irq);
    finish_test();
  end
endmodule : ims_status_bench
